// file: rtl/fault_alert_defines.svh
// Offsets, reset values, encodings and timing counts of the fault logic
`ifndef FAULT_ALERT_DEFINES_SVH
`define FAULT_ALERT_DEFINES_SVH

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define OFF_CONFIG 8'h00
`define OFF_STATUS 8'h04
`define OFF_ALERT_CTRL 8'h08
`define OFF_POSITIVE_FLAG_A_POS 8'h0c
`define OFF_POSITIVE_FLAG_A_NEG 8'h10
`define OFF_PEAK_POS 8'h14
`define OFF_PEAK_NEG 8'h18
`define OFF_IRQ_STATUS 8'h1c
`define OFF_IRQ_MASK 8'h20

// ----------------------------------------
// Reset values and encodings
// ----------------------------------------
`define CONFIG_RESET 6'h38
`define ALERT_CTRL_RESET 6'h00
`define MODE_POWER_DOWN 3'h0
`define MODE_ADC_OFF 3'h4
`define MODE_TRIG_LO 3'h1
`define MODE_TRIG_HI 3'h3
`define PEAK_POS_RESET 16'h8000
`define PEAK_NEG_RESET 16'h7fff
`define ARA_ADDR 7'h0c
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

// ----------------------------------------
// Timing
// ----------------------------------------
`define CLK_NS 20
`define STROBE_NS 4000
`define STROBE_CYCLES ((`STROBE_NS + `CLK_NS - 1) / `CLK_NS)
`define CF_MAX_US 960
`define CF_STEP 8'h10

`endif

// file: rtl/fault_alert_pkg.sv
// Types shared by the fault signalling logic
`default_nettype none

package fault_alert_pkg;

	typedef struct packed {
		logic alert;
		logic conversion_ready_flag;
		logic positive_flag_a_neg;
		logic positive_flag_a_pos;
		logic over;
		logic warn;
	} status_type;

	typedef struct packed {
		logic [2:0] mode;
		logic over_latch;
		logic warn_latch;
		logic positive_flag_a_latch;
	} config_type;

	typedef struct packed {
		logic critical_pin_enable;
		logic alert_output_enable;
		logic [3:0] mask;
	} alert_ctrl_type;

	typedef struct packed {
		logic [3:0] positive_flag_a_filter_select;
		logic [7:0] thr;
	} neg_thr_type;

	typedef enum logic [4:0] {
		ARA_IDLE = 5'h01,
		ARA_ADDR = 5'h02,
		ARA_ACK = 5'h04,
		ARA_SEND = 5'h08,
		ARA_WAIT = 5'h10
	} ara_state_type;

endpackage : fault_alert_pkg

`default_nettype wire

// file: rtl/positive_flag_a_filter.sv
// Critical comparator output filter, sampled on the strobe
`include "fault_alert_defines.svh"
`default_nettype none

module positive_flag_a_filter
	import fault_alert_pkg::*;
(
	// Clock and reset
	input wire logic clock,
	input wire logic ce,
	input wire logic nrst,
	// Sampling
	input wire logic strobe,
	input wire logic comparator_output,
	input wire logic [3:0] positive_flag_a_filter_select,
	// Result
	output logic trip
);

	logic [7:0] run;

	function automatic logic [7:0] limit(input logic [3:0] sel);
		limit = 8'(sel * `CF_STEP);
	endfunction : limit

	// ----------------------------------------
	// Run length of active samples
	// ----------------------------------------
	// One low sample restarts the run, so a toggling comparator trips only with filter select zero
	always_ff @(posedge clock)
		if (!nrst)
		begin
			run <= 8'h00;
			trip <= 1'b0;
		end
		else if (ce && strobe)
		begin
			if (!comparator_output)
			begin
				run <= 8'h00; // RULE4
				trip <= 1'b0;
			end
			else if (run >= limit(positive_flag_a_filter_select))
				trip <= 1'b1; // RULE3
			else
				run <= run + 8'h01;
		end

	a_trip_needs_sample: assert property (@(posedge clock) disable iff (!nrst) // RULE4
		$rose(trip) |-> $past(strobe && comparator_output && ce))
		else $error("trip rose without an active sample");
	a_trip_after_run: assert property (@(posedge clock) disable iff (!nrst) // RULE3
		$rose(trip) |-> $past(run) >= $past(limit(positive_flag_a_filter_select)))
		else $error("trip rose before the filter run ended");

endmodule : positive_flag_a_filter

`default_nettype wire

// file: rtl/fault_alert_logic.sv
// Fault signalling: critical filter, alert pin, alert response and flags
//
// Chosen here: the address map and the AXI4-Lite interface to the registers.
`include "fault_alert_defines.svh"
`default_nettype none
// Contract
// (RULE1) Shunt compared with separate positive and negative 0-255 mV limits.
// (RULE2) Critical pin enable gates only the pin, never the critical flags.
// (RULE3) Filter select sets how long the comparator must stay active.
// (RULE4) Sampled each strobe; every sample in the delay must be active.
// (RULE5) Host sets negative threshold beyond -2 mV plus margin, or -255 mV.
// (RULE6) Host uses latched critical mode when the pin drives an enable line.
// (RULE7) Alert on warning, over-limit, critical, triggered conversion ready.
// (RULE8) Alert held until status read or alert response; fault sets it again.
// (RULE9) Alert assertion never halts a conversion already running.
// (RULE10) Alert pin is open-drain, released high when its enable is off.
// (RULE11) On alert response address, a pending slave returns its own address.
// (RULE12) Arbitration loser does not acknowledge and keeps alert low.
// (RULE13) Internal alert flag cleared by status read or disabling alert.
// (RULE14) Flags zero after reset; read clears once converted and fault gone.
// (RULE15) Latches clear on status read or going transparent; set while fault.
// (RULE16) Peak register cleared by writing one to its lowest bit.
// (RULE17) Reset masks status, disables alert, outputs active-low transparent.
// (RULE18) Ready flag clears on config write, status read or convert trigger.
// (RULE19) Each critical flag records trips of its own threshold only.

module fault_alert_logic
	import fault_alert_pkg::*;
#(
	parameter logic [6:0] OWN_ADDR = 7'h40,
	parameter int ADDR_W = 8
)(
	// Clock, enable, reset
	input wire logic clock,
	input wire logic ce,
	input wire logic nrst,
	// AXI4-Lite register port
	input wire logic [ADDR_W-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [ADDR_W-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// Measurement side, same clock
	input wire logic signed [8:0] shunt_mv,
	input wire logic warn_fault,
	input wire logic over_fault,
	input wire logic conv_done,
	input wire logic [15:0] adc_sample,
	// Pins
	input wire logic convert_n,
	input wire logic scl_in,
	input wire logic sda_in,
	output logic sda_out,
	output logic sda_oe,
	output logic alert_out,
	output logic alert_oe,
	output logic positive_flag_a_out,
	output logic positive_flag_a_oe,
	output logic warn_n,
	output logic over_n,
	output logic irq
);

	default clocking cb @(posedge clock); endclocking
	default disable iff (!nrst);

	config_type cfg;
	alert_ctrl_type actl;
	neg_thr_type neg_thr;
	status_type flags;
	logic [7:0] pos_thr;
	logic [15:0] peak_pos, peak_neg;
	logic [3:0] irq_status, irq_mask;
	logic aw_held, w_held, conv_seen, alert_pending, ara_done;
	logic [ADDR_W-1:0] aw_addr;
	logic [31:0] w_data, rd_word;
	logic [3:0] w_strb;
	logic [7:0] strobe_cnt;
	logic strobe, pos_trip, neg_trip, rd_ok;
	logic warn_lq, over_lq, positive_flag_a_lq;
	logic cnv_m, cnv_s, cnv_q, scl_m, scl_s, scl_q, sda_m, sda_s, sda_q;

	function automatic logic [31:0] merge(input logic [31:0] old,
		input logic [31:0] data, input logic [3:0] strb);
		for (int i = 0; i < 4; i++)
			merge[8*i +: 8] = strb[i] ? data[8*i +: 8] : old[8*i +: 8];
	endfunction : merge

	function automatic logic mapped(input logic [ADDR_W-1:0] a);
		mapped = (a[1:0] == 2'b00) && (a <= ADDR_W'(`OFF_IRQ_MASK));
	endfunction : mapped

	// ----------------------------------------
	// Bus slave
	// ----------------------------------------
	wire aw_hs = s_axi_awvalid && s_axi_awready;
	wire w_hs = s_axi_wvalid && s_axi_wready;
	wire ar_hs = s_axi_arvalid && s_axi_arready;
	wire do_wr = aw_held && w_held && !s_axi_bvalid;
	wire rd_status = ar_hs && (s_axi_araddr == ADDR_W'(`OFF_STATUS));
	wire [31:0] wv = w_data;

	function automatic logic wsel(input logic [7:0] off, input logic go,
		input logic [ADDR_W-1:0] a);
		wsel = go && (a == ADDR_W'(off));
	endfunction : wsel

	wire wr_cfg = wsel(`OFF_CONFIG, do_wr, aw_addr);
	wire [5:0] cfg_new = 6'(merge({26'h0, cfg}, wv, w_strb));

	always_ff @(posedge clock)
		if (!nrst)
		begin
			s_axi_awready <= 1'b1;
			s_axi_wready <= 1'b1;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= `RESP_OKAY;
			aw_held <= 1'b0;
			w_held <= 1'b0;
			aw_addr <= '0;
			w_data <= 32'h0;
			w_strb <= 4'h0;
		end
		else if (ce)
		begin
			if (aw_hs)
			begin
				aw_held <= 1'b1;
				s_axi_awready <= 1'b0;
				aw_addr <= s_axi_awaddr;
			end
			if (w_hs)
			begin
				w_held <= 1'b1;
				s_axi_wready <= 1'b0;
				w_data <= s_axi_wdata;
				w_strb <= s_axi_wstrb;
			end
			if (do_wr)
			begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= mapped(aw_addr) ? `RESP_OKAY : `RESP_SLVERR;
				aw_held <= 1'b0;
				w_held <= 1'b0;
			end
			if (s_axi_bvalid && s_axi_bready)
			begin
				s_axi_bvalid <= 1'b0;
				s_axi_awready <= 1'b1;
				s_axi_wready <= 1'b1;
			end
		end

	always_comb
	begin
		rd_ok = mapped(s_axi_araddr);
		unique case (s_axi_araddr[7:0])
			`OFF_CONFIG: rd_word = {26'h0, cfg};
			`OFF_STATUS: rd_word = {26'h0, flags};
			`OFF_ALERT_CTRL: rd_word = {26'h0, actl};
			`OFF_POSITIVE_FLAG_A_POS: rd_word = {24'h0, pos_thr};
			`OFF_POSITIVE_FLAG_A_NEG: rd_word = {20'h0, neg_thr};
			`OFF_PEAK_POS: rd_word = {16'h0, peak_pos};
			`OFF_PEAK_NEG: rd_word = {16'h0, peak_neg};
			`OFF_IRQ_STATUS: rd_word = {28'h0, irq_status};
			`OFF_IRQ_MASK: rd_word = {28'h0, irq_mask};
			default: rd_word = 32'h0;
		endcase
	end

	always_ff @(posedge clock)
		if (!nrst)
		begin
			s_axi_arready <= 1'b1;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0;
			s_axi_rresp <= `RESP_OKAY;
		end
		else if (ce)
		begin
			if (ar_hs)
			begin
				s_axi_arready <= 1'b0;
				s_axi_rvalid <= 1'b1;
				s_axi_rdata <= rd_ok ? rd_word : 32'h0;
				s_axi_rresp <= rd_ok ? `RESP_OKAY : `RESP_SLVERR;
			end
			else if (s_axi_rvalid && s_axi_rready)
			begin
				s_axi_rvalid <= 1'b0;
				s_axi_arready <= 1'b1;
			end
		end

	// ----------------------------------------
	// Control registers
	// ----------------------------------------
	always_ff @(posedge clock)
		if (!nrst)
		begin
			cfg <= `CONFIG_RESET; // RULE17
			actl <= `ALERT_CTRL_RESET; // RULE17
			pos_thr <= 8'h00;
			neg_thr <= 12'h000;
			irq_mask <= 4'h0;
		end
		else if (ce)
		begin
			if (wr_cfg)
				cfg <= cfg_new;
			if (wsel(`OFF_ALERT_CTRL, do_wr, aw_addr))
				actl <= 6'(merge({26'h0, actl}, wv, w_strb));
			if (wsel(`OFF_POSITIVE_FLAG_A_POS, do_wr, aw_addr))
				pos_thr <= 8'(merge({24'h0, pos_thr}, wv, w_strb)); // RULE1
			if (wsel(`OFF_POSITIVE_FLAG_A_NEG, do_wr, aw_addr))
				neg_thr <= 12'(merge({20'h0, neg_thr}, wv, w_strb)); // RULE1 RULE3
			if (wsel(`OFF_IRQ_MASK, do_wr, aw_addr))
				irq_mask <= 4'(merge({28'h0, irq_mask}, wv, w_strb));
		end

	// ----------------------------------------
	// Critical comparator and filter
	// ----------------------------------------
	// Offset near zero is left to software through the negative limit
	wire cmp_pos = shunt_mv > $signed({1'b0, pos_thr}); // RULE1 RULE5
	wire cmp_neg = -shunt_mv > $signed({1'b0, neg_thr.thr}); // RULE1

	always_ff @(posedge clock)
		if (!nrst)
			strobe_cnt <= 8'h00;
		else if (ce)
			strobe_cnt <= strobe ? 8'h00 : strobe_cnt + 8'h01;
	assign strobe = strobe_cnt == 8'(`STROBE_CYCLES - 1);

	positive_flag_a_filter u_filt_pos (.clock(clock), .ce(ce), .nrst(nrst),
		.strobe(strobe), .comparator_output(cmp_pos),
		.positive_flag_a_filter_select(neg_thr.positive_flag_a_filter_select), .trip(pos_trip));
	positive_flag_a_filter u_filt_neg (.clock(clock), .ce(ce), .nrst(nrst),
		.strobe(strobe), .comparator_output(cmp_neg),
		.positive_flag_a_filter_select(neg_thr.positive_flag_a_filter_select), .trip(neg_trip));

	// ----------------------------------------
	// Status flags, latches, pins
	// ----------------------------------------
	wire cnv_trig = cnv_q && !cnv_s
		&& cfg.mode >= `MODE_TRIG_LO && cfg.mode <= `MODE_TRIG_HI;
	wire triggered = cfg.mode >= `MODE_TRIG_LO && cfg.mode <= `MODE_TRIG_HI;
	wire clr_ok = rd_status && conv_seen;
	wire conversion_ready_flag_clr = rd_status || cnv_trig || (wr_cfg // RULE18
		&& cfg_new[5:3] != `MODE_POWER_DOWN && cfg_new[5:3] != `MODE_ADC_OFF);
	wire alert_cause = (warn_fault && actl.mask[0]) // RULE7
		|| (over_fault && actl.mask[1])
		|| ((pos_trip || neg_trip) && actl.mask[2])
		|| (conv_done && triggered && actl.mask[3]);

	// Set wins over every status-read clear below, so no event is lost on a read
	always_ff @(posedge clock)
		if (!nrst)
		begin
			flags <= '0; // RULE14
			conv_seen <= 1'b0;
			{cnv_m, cnv_s, cnv_q} <= 3'b111;
			{warn_lq, over_lq, positive_flag_a_lq} <= 3'b000;
			alert_pending <= 1'b0;
		end
		else if (ce)
		begin
			cnv_m <= convert_n;
			cnv_s <= cnv_m;
			cnv_q <= cnv_s;
			conv_seen <= conv_done || (conv_seen && !rd_status);
			flags.warn <= warn_fault || (flags.warn && !(clr_ok && !warn_fault)); // RULE14
			flags.over <= over_fault || (flags.over && !(clr_ok && !over_fault));
			flags.positive_flag_a_pos <= pos_trip || (flags.positive_flag_a_pos && !clr_ok); // RULE2 RULE19
			flags.positive_flag_a_neg <= neg_trip || (flags.positive_flag_a_neg && !clr_ok); // RULE19
			flags.conversion_ready_flag <= conv_done || (flags.conversion_ready_flag && !conversion_ready_flag_clr); // RULE18
			flags.alert <= actl.alert_output_enable // RULE13
				&& (alert_cause || (flags.alert && !rd_status));
			warn_lq <= cfg.warn_latch && (warn_fault || (warn_lq && !rd_status)); // RULE15
			over_lq <= cfg.over_latch && (over_fault || (over_lq && !rd_status));
			positive_flag_a_lq <= cfg.positive_flag_a_latch
				&& (pos_trip || neg_trip || (positive_flag_a_lq && !rd_status)); // RULE6 RULE15
			alert_pending <= alert_cause // RULE8 RULE12
				|| (alert_pending && !rd_status && !ara_done);
		end

	// Pins only; the alert path never feeds the conversion sequencer
	always_ff @(posedge clock)
		if (!nrst)
		begin
			warn_n <= 1'b1; // RULE17
			over_n <= 1'b1;
			positive_flag_a_oe <= 1'b0;
			alert_oe <= 1'b0;
			positive_flag_a_out <= 1'b0;
			alert_out <= 1'b0;
			sda_out <= 1'b0;
		end
		else if (ce)
		begin
			warn_n <= !(cfg.warn_latch ? warn_lq : warn_fault);
			over_n <= !(cfg.over_latch ? over_lq : over_fault);
			positive_flag_a_oe <= actl.critical_pin_enable // RULE2
				&& (cfg.positive_flag_a_latch ? positive_flag_a_lq : (pos_trip || neg_trip));
			alert_oe <= actl.alert_output_enable && alert_pending; // RULE9 RULE10
		end

	// ----------------------------------------
	// Peak hold, interrupt
	// ----------------------------------------
	always_ff @(posedge clock)
		if (!nrst)
		begin
			peak_pos <= `PEAK_POS_RESET;
			peak_neg <= `PEAK_NEG_RESET;
			irq_status <= 4'h0;
			irq <= 1'b0;
		end
		else if (ce)
		begin
			if (wsel(`OFF_PEAK_POS, do_wr, aw_addr) && w_strb[0] && wv[0])
				peak_pos <= `PEAK_POS_RESET; // RULE16
			else if (conv_done && $signed(adc_sample) > $signed(peak_pos))
				peak_pos <= adc_sample;
			if (wsel(`OFF_PEAK_NEG, do_wr, aw_addr) && w_strb[0] && wv[0])
				peak_neg <= `PEAK_NEG_RESET; // RULE16
			else if (conv_done && $signed(adc_sample) < $signed(peak_neg))
				peak_neg <= adc_sample;
			irq_status <= {conv_done, alert_cause, neg_trip, pos_trip}
				| (irq_status & ~(wsel(`OFF_IRQ_STATUS, do_wr, aw_addr)
				&& w_strb[0] ? wv[3:0] : 4'h0));
			irq <= |(irq_status & irq_mask);
		end

	// ----------------------------------------
	// Alert response on the two-wire link
	// ----------------------------------------
	ara_state_type st;
	logic [7:0] shreg;
	logic [3:0] bits;
	wire scl_rise = scl_s && !scl_q;
	wire scl_fall = !scl_s && scl_q;
	wire bus_start = scl_s && scl_q && sda_q && !sda_s;
	wire bus_stop = scl_s && scl_q && !sda_q && sda_s;

	// Link runs about eight clocks per bit, so a one-cycle drive lag is safe
	always_ff @(posedge clock)
		if (!nrst)
		begin
			{scl_m, scl_s, scl_q, sda_m, sda_s, sda_q} <= 6'h3f;
			st <= ARA_IDLE;
			shreg <= 8'h00;
			bits <= 4'h0;
			ara_done <= 1'b0;
			sda_oe <= 1'b0;
		end
		else if (ce)
		begin
			{scl_m, scl_s, scl_q} <= {scl_in, scl_m, scl_s};
			{sda_m, sda_s, sda_q} <= {sda_in, sda_m, sda_s};
			ara_done <= 1'b0;
			sda_oe <= (st == ARA_ACK) || (st == ARA_SEND && !shreg[7]);
			if (bus_start)
			begin
				st <= ARA_ADDR;
				bits <= 4'h0;
			end
			else if (bus_stop)
				st <= ARA_IDLE;
			else
				unique case (st)
					ARA_IDLE: ;
					ARA_ADDR:
						if (scl_rise)
						begin
							shreg <= {shreg[6:0], sda_s};
							bits <= bits + 4'h1;
						end
						else if (scl_fall && bits == 4'h8)
							st <= (shreg == {`ARA_ADDR, 1'b1} && alert_pending)
								? ARA_ACK : ARA_IDLE; // RULE11
					ARA_ACK:
						if (scl_fall)
						begin
							st <= ARA_SEND;
							shreg <= {OWN_ADDR, 1'b0}; // RULE11
							bits <= 4'h0;
						end
					ARA_SEND:
						if (scl_rise && shreg[7] && !sda_s)
							st <= ARA_IDLE; // RULE12
						else if (scl_fall)
						begin
							shreg <= {shreg[6:0], 1'b1};
							bits <= bits + 4'h1;
							if (bits == 4'h7)
								st <= ARA_WAIT;
						end
					ARA_WAIT:
						if (scl_rise)
						begin
							ara_done <= 1'b1; // RULE8
							st <= ARA_IDLE;
						end
				endcase
		end

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	a_pos_compare: assert property (cmp_pos |-> !shunt_mv[8]) // RULE1
		else $error("positive compare on negative shunt");
	a_flag_ungated: assert property ($rose(pos_trip) && ce |=> flags.positive_flag_a_pos) // RULE2
		else $error("positive flag missed a trip");
	a_alert_cause: assert property (alert_cause && ce |=> alert_pending) // RULE7
		else $error("alert cause not latched");
	a_alert_held: assert property (alert_pending && !rd_status && !ara_done // RULE8
		|=> alert_pending) else $error("alert dropped without clear");
	a_alert_release: assert property (!actl.alert_output_enable && ce // RULE10
		|=> !alert_oe) else $error("alert driven while disabled");
	a_flag_clear: assert property ($fell(flags.warn) |-> // RULE14
		$past(rd_status && conv_seen && !warn_fault))
		else $error("warning flag cleared early");
	a_latch_transparent: assert property (!cfg.positive_flag_a_latch && ce // RULE15
		|=> !positive_flag_a_lq) else $error("latch kept in transparent mode");
	a_conversion_ready_flag_clear: assert property ($fell(flags.conversion_ready_flag) |-> $past(conversion_ready_flag_clr)) // RULE18
		else $error("ready flag cleared without cause");
	a_ara_reply: assert property ($rose(st == ARA_SEND) // RULE11
		|-> shreg == {OWN_ADDR, 1'b0}) else $error("wrong reply address");

	c_positive_flag_a_trip: cover property ($rose(positive_flag_a_oe));
	c_ara_done: cover property (ara_done);
	c_ara_lost: cover property (st == ARA_SEND ##1 st == ARA_IDLE && alert_pending);
	c_status_read: cover property (rd_status && flags.warn);

endmodule : fault_alert_logic

`default_nettype wire

// file: sim/smbus_host_model.sv
// Behavioural host master for the alert response exchange
`include "fault_alert_defines.svh"
`default_nettype none

module smbus_host_model
(
	// Link lines, pull-ups on the wires
	output logic scl,
	output logic sda_oe,
	input wire logic sda
);
	timeunit 1ns;
	timeprecision 1ps;

	// Clock stands high between frames
	initial
	begin
		scl = 1'b1;
		sda_oe = 1'b0;
	end

	// One bit: data set mid-low, read late in the high phase
	task clk_bit(input logic pull, output logic seen);
		#40 sda_oe = pull;
		#40 scl = 1'b1;
		#70 seen = sda;
		#10 scl = 1'b0;
	endtask : clk_bit

	// Rival bits stand in for a second slave answering at once
	task ara(input logic [7:0] rival, output logic [7:0] rx,
		output logic ack);
		logic s;
		logic [7:0] hdr;
		// Keep every line change off the block's clock edges
		#5;
		hdr = {`ARA_ADDR, 1'b1};
		sda_oe = 1'b1;
		#80 scl = 1'b0;
		for (int i = 7; i >= 0; i--)
			clk_bit(!hdr[i], s);
		clk_bit(1'b0, s);
		ack = !s;
		for (int i = 7; i >= 0; i--)
		begin
			clk_bit(!rival[i], s);
			rx[i] = s;
		end
		clk_bit(1'b0, s);
		#40 sda_oe = 1'b1;
		#40 scl = 1'b1;
		#80 sda_oe = 1'b0;
	endtask : ara
endmodule : smbus_host_model

`default_nettype wire

// file: sim/tb.sv
// Self-checking bench for the fault signalling block
`include "fault_alert_defines.svh"
`default_nettype none

module tb;
	timeunit 1ns;
	timeprecision 1ps;

	// ----
	// Signals
	// ----
	localparam logic [6:0] own_addr = 7'h40;
	logic clock, ce, nrst, convert_n, scl, host_oe;
	logic [7:0] s_axi_awaddr, s_axi_araddr, rx;
	logic [31:0] s_axi_wdata, s_axi_rdata;
	logic [3:0] s_axi_wstrb;
	logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
	logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
	logic s_axi_rvalid, s_axi_rready, ack;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic signed [8:0] shunt_mv;
	logic warn_fault, over_fault, conv_done;
	logic [15:0] adc_sample;
	logic sda_out, sda_oe, alert_out, alert_oe, positive_flag_a_out, positive_flag_a_oe;
	logic warn_n, over_n, irq;
	wire logic sda;
	int n_mismatch = 0;
	int n_compared = 0;
	int cyc = 0;

	// Open-drain wire with pull-up
	assign sda = !(sda_oe || host_oe);

	fault_alert_logic #(.OWN_ADDR(own_addr), .ADDR_W(8)) i_dut
	(
		.clock, .ce, .nrst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
		.s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
		.s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
		.s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
		.s_axi_rvalid, .s_axi_rready, .shunt_mv, .warn_fault, .over_fault,
		.conv_done, .adc_sample, .convert_n, .scl_in(scl), .sda_in(sda),
		.sda_out, .sda_oe, .alert_out, .alert_oe, .positive_flag_a_out, .positive_flag_a_oe,
		.warn_n, .over_n, .irq
	);

	smbus_host_model i_host (.scl, .sda_oe(host_oe), .sda);

	initial
	begin
		clock = 1'b0;
		forever #10 clock = ~clock;
	end

	// Hang guard, well above the longest filter wait
	always @(posedge clock)
	begin
		cyc++;
		if (cyc == 20000)
		begin
			n_mismatch++;
			wrap_up();
		end
	end

	// ----
	// Shared tasks
	// ----
	task wrap_up();
		$display("compared %0d mismatches %0d", n_compared, n_mismatch);
		if (n_mismatch == 0 && n_compared > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : wrap_up

	task chk(input string n, input logic [31:0] e, input logic [31:0] g);
		n_compared++;
		if (g !== e)
		begin
			n_mismatch++;
			$display("wrong value %s expected %h seen %h", n, e, g);
		end
	endtask : chk

	task wt(input int n);
		repeat (n) @(posedge clock);
	endtask : wt

	task wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clock);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_wstrb <= 4'hf;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do
		begin
			@(posedge clock);
			if (s_axi_awready && s_axi_awvalid)
				s_axi_awvalid <= 1'b0;
			if (s_axi_wready && s_axi_wvalid)
				s_axi_wvalid <= 1'b0;
		end
		while (!s_axi_bvalid);
		s_axi_bready <= 1'b0;
		chk("bresp", `RESP_OKAY, s_axi_bresp);
	endtask : wr

	task rd(input logic [7:0] a, output logic [31:0] d,
		output logic [1:0] r);
		@(posedge clock);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do
		begin
			@(posedge clock);
			if (s_axi_arready && s_axi_arvalid)
				s_axi_arvalid <= 1'b0;
		end
		while (!s_axi_rvalid);
		s_axi_rready <= 1'b0;
		d = s_axi_rdata;
		r = s_axi_rresp;
	endtask : rd

	task rc(input string n, input logic [7:0] a, input logic [31:0] m, e);
		logic [31:0] d;
		logic [1:0] r;
		rd(a, d, r);
		chk(n, e, d & m);
	endtask : rc

	task conv(input logic [15:0] s);
		@(posedge clock);
		adc_sample <= s;
		conv_done <= 1'b1;
		@(posedge clock);
		conv_done <= 1'b0;
	endtask : conv

	task flt();
		@(posedge clock);
		warn_fault <= 1'b1;
		over_fault <= 1'b1;
		wt(4);
		warn_fault <= 1'b0;
		over_fault <= 1'b0;
		wt(3);
	endtask : flt

	// ----
	// Scenarios
	// ----
	task t_reset();
		logic [31:0] d;
		logic [1:0] r;
		chk("alert_oe", 1'b0, alert_oe);
		chk("warn_n", 1'b1, warn_n);
		chk("od pins", 32'h0, {sda_out, alert_out, positive_flag_a_out});
		rc("alert_ctrl", `OFF_ALERT_CTRL, 32'h3f, `ALERT_CTRL_RESET);
		rc("config", `OFF_CONFIG, 32'h3f, `CONFIG_RESET);
		rc("status", `OFF_STATUS, 32'h3f, 32'h0);
		rc("peak_neg", `OFF_PEAK_NEG, 32'hffff, `PEAK_NEG_RESET);
		rd(8'h24, d, r);
		chk("unmapped", `RESP_SLVERR, r);
		$display("test reset done");
	endtask : t_reset

	task t_positive_flag_a();
		wr(`OFF_POSITIVE_FLAG_A_POS, 32'h0a);
		wr(`OFF_POSITIVE_FLAG_A_NEG, 32'hc8);
		wr(`OFF_ALERT_CTRL, 32'h0);
		shunt_mv <= 9'sd20;
		wt(230);
		chk("positive_flag_a_oe gated", 1'b0, positive_flag_a_oe);
		rc("positive_flag_a flags", `OFF_STATUS, 32'hc, 32'h4);
		shunt_mv <= 9'sd0;
		wt(230);
		conv(16'h0);
		rc("positive_flag_a flags", `OFF_STATUS, 32'hc, 32'h4);
		rc("flags clear", `OFF_STATUS, 32'hc, 32'h0);
		// Latched mode, as the pin may drive an enable line
		wr(`OFF_CONFIG, 32'h39);
		wr(`OFF_POSITIVE_FLAG_A_NEG, 32'h114);
		wr(`OFF_ALERT_CTRL, 32'h20);
		shunt_mv <= -9'sd50;
		wt(3000);
		chk("positive_flag_a_oe early", 1'b0, positive_flag_a_oe);
		wt(420);
		chk("positive_flag_a_oe", 1'b1, positive_flag_a_oe);
		shunt_mv <= 9'sd0;
		wt(230);
		conv(16'h0);
		rc("positive_flag_a flags", `OFF_STATUS, 32'hc, 32'h8);
		wt(3);
		chk("positive_flag_a latch", 1'b0, positive_flag_a_oe);
		wr(`OFF_CONFIG, 32'h38);
		$display("test positive_flag_a done");
	endtask : t_positive_flag_a

	task t_irq();
		wr(`OFF_IRQ_MASK, 32'h2);
		wt(3);
		chk("irq", 1'b1, irq);
		wr(`OFF_IRQ_MASK, 32'h0);
		wt(3);
		chk("irq masked", 1'b0, irq);
		wr(`OFF_IRQ_STATUS, 32'hf);
		rc("irq_status", `OFF_IRQ_STATUS, 32'hf, 32'h0);
		$display("test irq done");
	endtask : t_irq

	task t_alert();
		wr(`OFF_ALERT_CTRL, 32'h11);
		flt();
		chk("alert_oe", 1'b1, alert_oe);
		conv(16'h0);
		wt(20);
		chk("alert_oe held", 1'b1, alert_oe);
		i_host.ara(8'hff, rx, ack);
		chk("ack", 1'b1, ack);
		chk("own address", {own_addr, 1'b0}, rx);
		wt(5);
		chk("alert_oe", 1'b0, alert_oe);
		rc("alert flag", `OFF_STATUS, 32'h21, 32'h21);
		rc("flags clear", `OFF_STATUS, 32'h21, 32'h0);
		// Lower address 0x20 wins the response
		flt();
		i_host.ara(8'h40, rx, ack);
		chk("winner", 8'h40, rx);
		wt(5);
		chk("alert_oe kept", 1'b1, alert_oe);
		wr(`OFF_ALERT_CTRL, 32'h01);
		wt(3);
		chk("alert_oe off", 1'b0, alert_oe);
		rc("alert flag", `OFF_STATUS, 32'h20, 32'h0);
		i_host.ara(8'hff, rx, ack);
		chk("no ack", 1'b0, ack);
		$display("test alert done");
	endtask : t_alert

	task t_latch();
		wr(`OFF_CONFIG, 32'h3a);
		flt();
		chk("warn_n latched", 1'b0, warn_n);
		chk("over_n", 1'b1, over_n);
		conv(16'h0);
		rc("conversion_ready_flag set", `OFF_STATUS, 32'h10, 32'h10);
		wt(3);
		chk("warn_n read", 1'b1, warn_n);
		flt();
		conv(16'h0);
		wr(`OFF_CONFIG, 32'h38);
		wr(`OFF_CONFIG, 32'h3a);
		wt(3);
		chk("warn_n toggle", 1'b1, warn_n);
		rc("conversion_ready_flag clear", `OFF_STATUS, 32'h10, 32'h0);
		$display("test latch done");
	endtask : t_latch

	task t_trig();
		wr(`OFF_CONFIG, 32'h08);
		wr(`OFF_ALERT_CTRL, 32'h18);
		conv(16'h0);
		wt(2);
		chk("alert_oe trig", 1'b1, alert_oe);
		convert_n <= 1'b0;
		wt(5);
		convert_n <= 1'b1;
		rc("conversion_ready_flag trig", `OFF_STATUS, 32'h30, 32'h20);
		wr(`OFF_CONFIG, 32'h38);
		wr(`OFF_ALERT_CTRL, 32'h0);
		$display("test trig done");
	endtask : t_trig

	task t_peak();
		conv(16'h0123);
		rc("peak_pos", `OFF_PEAK_POS, 32'hffff, 32'h0123);
		wr(`OFF_PEAK_POS, 32'h1);
		rc("peak_pos clr", `OFF_PEAK_POS, 32'hffff, `PEAK_POS_RESET);
		$display("test peak done");
	endtask : t_peak

	initial
	begin
		ce = 1'b1;
		nrst = 1'b0;
		convert_n = 1'b1;
		s_axi_awaddr = 8'h0;
		s_axi_araddr = 8'h0;
		s_axi_wdata = 32'h0;
		s_axi_wstrb = 4'h0;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'h0;
		{s_axi_arvalid, s_axi_rready} = 2'h0;
		shunt_mv = 9'sd0;
		{warn_fault, over_fault, conv_done} = 3'h0;
		adc_sample = 16'h0;
		repeat (6) @(posedge clock);
		nrst <= 1'b1;
		t_reset();
		t_positive_flag_a();
		t_irq();
		t_alert();
		t_latch();
		t_trig();
		t_peak();
		wrap_up();
	end
endmodule : tb

`default_nettype wire
